// ---- rtl/dsm_pkg.sv ----
// Package: register map, field layout and carrier types of the DMA status block
package dsm_pkg;
   // Register byte offsets
   localparam logic [11:0] DSM_OFS_CHAN_CMD = 12'h014;
   localparam logic [11:0] DSM_OFS_IRQ_STATUS = 12'h02C;
   localparam logic [11:0] DSM_OFS_EV_STATUS = 12'h030;
   localparam logic [11:0] DSM_OFS_EV_MASK = 12'h034;
   localparam logic [11:0] DSM_OFS_MON_CTRL = 12'h800;
   localparam logic [11:0] DSM_OFS_S0_DATA = 12'h804;
   localparam logic [11:0] DSM_OFS_S0_STALL = 12'h808;
   // Reset values
   localparam logic [31:0] DSM_RST_MON_CTRL = 32'h00000000;
   localparam logic [3:0] DSM_RST_EV_MASK = 4'h0;
   localparam logic [15:0] DSM_RST_COUNT = 16'h0000;
   // Channel status and command fields
   localparam int DSM_BIT_RZ = 0;
   localparam int DSM_BIT_CMPL = 1;
   localparam int DSM_BIT_ERR = 2;
   localparam int DSM_BIT_ERROR_CLEAR_CMD = 8;
   // Monitor control fields
   localparam int DSM_BIT_S0_EN = 0;
   localparam int DSM_BIT_S1_EN = 1;
   localparam int DSM_BIT_S0_FRZ = 4;
   localparam int DSM_BIT_S1_FRZ = 5;
   localparam int DSM_BIT_S0_CLR = 8;
   localparam int DSM_BIT_S1_CLR = 9;
   localparam int DSM_POS_S0_SEL = 16;
   localparam int DSM_POS_S1_SEL = 24;
   localparam int DSM_SEL_W = 6;
   // Writable bits of the monitor control register
   localparam logic [31:0] DSM_MON_CTRL_WMASK = 32'h3F3F0033;
   // Event status bits
   localparam int DSM_EV_RZ = 0;
   localparam int DSM_EV_CMPL = 1;
   localparam int DSM_EV_ERR = 2;
   localparam int DSM_EV_OVF = 3;

   // Per-slot observation strobes
   typedef struct packed {
      logic rd_data;
      logic rd_stall;
   } dsm_mon_ev_s;

   // Loads of counter and reload value from the channel's own registers
   typedef struct packed {
      logic cnt_load;
      logic [15:0] cnt_val;
      logic rld_load;
      logic [15:0] rld_val;
   } dsm_chan_load_s;
endpackage

// ---- rtl/dsm_slot_counter.sv ----
// Data-cycle and stall-cycle counters of one monitor slot
`timescale 1ns/1ns
module dsm_slot_counter
   import dsm_pkg::*;
#(
   parameter int W = 32
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Control
   input wire logic slot_enable,
   input wire logic freeze,
   input wire logic clear,
   input wire dsm_mon_ev_s ev,
   // Counts
   output logic [W-1:0] data_count,
   output logic [W-1:0] stall_count,
   output logic overflow
);
   typedef struct packed {
      logic [W-1:0] data;
      logic [W-1:0] stall;
      logic frozen;
      logic ovf;
   } dsm_slot_state_s;

   localparam logic [W-1:0] MAXV = '1;

   dsm_slot_state_s s_q, s_d;
   logic wrap;

   always_comb begin
      s_d = s_q;
      s_d.ovf = 1'b0;
      wrap = (ev.rd_data && s_q.data == MAXV) ||
             (ev.rd_stall && s_q.stall == MAXV);
      if (clear) begin // RQ6
         s_d = '0;
      end else if (slot_enable && !s_q.frozen) begin // RQ10 RQ15
         if (wrap) begin
            s_d.ovf = 1'b1;
            if (freeze) begin
               s_d.frozen = 1'b1; // RQ9
            end else begin
               s_d.data = '0; // RQ8
               s_d.stall = '0;
            end
         end else begin
            s_d.data = s_q.data + W'(ev.rd_data); // RQ11
            s_d.stall = s_q.stall + W'(ev.rd_stall); // RQ12
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign data_count = s_q.data;
   assign stall_count = s_q.stall;
   assign overflow = s_q.ovf;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_data_count_step: assert property ( // RQ11
      (slot_enable && !clear && !s_q.frozen && ev.rd_data &&
       !wrap) |=> data_count == $past(data_count) + 1)
      else $error("data count did not step");
   chk_wrap_reset: assert property ( // RQ8
      (slot_enable && !clear && !s_q.frozen && wrap && !freeze)
      |=> data_count == 0 && stall_count == 0 && overflow)
      else $error("overflow without freeze did not reset counters");
   chk_freeze_hold: assert property ( // RQ9
      (slot_enable && !clear && !s_q.frozen && wrap && freeze)
      |=> $stable(data_count) && $stable(stall_count) [*2])
      else $error("frozen slot kept counting");
   chk_disabled_hold: assert property ( // RQ15
      (!slot_enable && !clear) |=> $stable(data_count) &&
      $stable(stall_count))
      else $error("disabled slot changed its counts");
   cov_wrap: cover property (slot_enable && wrap && !clear);
endmodule // dsm_slot_counter

// ---- rtl/dsm_top.sv ----
// Channel status flags, event interrupt and slot-0 performance monitor
//
// What this block does
// RQ1 - Error flag sets on any transfer error and stays until cleared.
// RQ2 - Complete flag high exactly when counter and reload are both zero.
// RQ3 - Reload-zero flag high exactly while the reload value is zero.
// RQ4 - Control bits 21:16 and 29:24 pick each slot's observed channel; only 21:16 is used, bits 29:24 are stored but there is no slot 1.
// RQ5 - Software must not point both slots at one channel.
// RQ6 - Writing one to a slot clear bit zeroes its counters; the slot 1 clear bit drives nothing, as there is no slot 1.
// RQ7 - Slot clear bits always read back as zero.
// RQ8 - Without freeze, overflow resets that slot's counters.
// RQ9 - With freeze, the slot stops just before an overflow.
// RQ10 - Control bits 0 and 1 enable slot 0 and slot 1; bit 1 is stored but drives nothing, as there is no slot 1.
// RQ11 - Read-only 32-bit count of slot-0 read data cycles.
// RQ12 - Read-only 32-bit count of slot-0 read stall cycles.
// RQ13 - Error-clear command clears the error flag and lets transfers run.
// RQ14 - Counter reloads from nonzero reload at zero, else channel stops.
// RQ15 - Slot counters advance only while the slot is enabled.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
module dsm_top
   import dsm_pkg::*;
#(
   parameter int NUM_CH = 64,
   parameter int CNT_W = 32
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Channel transfer side
   input wire dsm_chan_load_s chan_load,
   input wire logic xfer_beat,
   input wire logic xfer_err_in,
   output logic chan_run,
   // Monitor strobes, one bit per DMA channel
   input wire logic [NUM_CH-1:0] rd_data_ev,
   input wire logic [NUM_CH-1:0] rd_stall_ev,
   // Interrupt
   output logic irq
);
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic chan_run;
      logic err_flag;
      logic [15:0] xfer_counter;
      logic [15:0] reload_value;
      logic [31:0] mon_ctrl;
      logic [3:0] ev_stat;
      logic [3:0] ev_mask;
      logic cmpl_prev;
      logic rz_prev;
   } dsm_state_s;

   dsm_state_s s_q, s_d;

   // Slot 0 wiring
   logic s0_clear;
   logic s1_clear;
   logic s0_ovf;
   logic [CNT_W-1:0] s0_data;
   logic [CNT_W-1:0] s0_stall;
   dsm_mon_ev_s s0_ev;
   logic [DSM_SEL_W-1:0] s0_sel;

   // Bus decode
   logic acc_setup;
   logic acc_done;
   logic wr_done;
   logic [31:0] rd_word;
   logic [31:0] irq_status_word;
   logic cmpl_now;
   logic rz_now;
   logic error_clear_cmd;

   function automatic logic dsm_mapped(input logic [11:0] a);
      return a == DSM_OFS_CHAN_CMD || a == DSM_OFS_IRQ_STATUS ||
             a == DSM_OFS_EV_STATUS || a == DSM_OFS_EV_MASK ||
             a == DSM_OFS_MON_CTRL || a == DSM_OFS_S0_DATA ||
             a == DSM_OFS_S0_STALL;
   endfunction

   // Pick one channel's strobe; out-of-range selects see nothing
   function automatic logic dsm_pick(input logic [NUM_CH-1:0] v,
                                     input logic [DSM_SEL_W-1:0] sel);
      logic r;
      r = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (sel == DSM_SEL_W'(i)) begin
            r = v[i];
         end
      end
      return r;
   endfunction

   assign cmpl_now = s_q.xfer_counter == 16'h0000 &&
                     s_q.reload_value == 16'h0000; // RQ2
   assign rz_now = s_q.reload_value == 16'h0000; // RQ3
   assign irq_status_word = {29'h0, s_q.err_flag, cmpl_now, rz_now};

   assign acc_setup = psel && penable && !s_q.pready;
   assign acc_done = psel && penable && s_q.pready;
   assign wr_done = acc_done && pwrite;
   assign error_clear_cmd = wr_done && paddr == DSM_OFS_CHAN_CMD &&
                 pwdata[DSM_BIT_ERROR_CLEAR_CMD];
   assign s0_clear = wr_done && paddr == DSM_OFS_MON_CTRL &&
                     pwdata[DSM_BIT_S0_CLR];
   assign s1_clear = wr_done && paddr == DSM_OFS_MON_CTRL &&
                     pwdata[DSM_BIT_S1_CLR];

   // Slot 0 observes the channel named in its select field
   assign s0_ev.rd_data = dsm_pick(rd_data_ev,
      s_q.mon_ctrl[DSM_POS_S0_SEL +: DSM_SEL_W]); // RQ4
   assign s0_ev.rd_stall = dsm_pick(rd_stall_ev,
      s_q.mon_ctrl[DSM_POS_S0_SEL +: DSM_SEL_W]); // RQ4
   assign s0_sel = s_q.mon_ctrl[DSM_POS_S0_SEL +: DSM_SEL_W]; // RQ4

   dsm_slot_counter #(
      .W(CNT_W)
   ) u_slot0 (
      .core_clk(core_clk),
      .rst(rst),
      .slot_enable(s_q.mon_ctrl[DSM_BIT_S0_EN]), // RQ10
      .freeze(s_q.mon_ctrl[DSM_BIT_S0_FRZ]),
      .clear(s0_clear), // RQ6
      .ev(s0_ev),
      .data_count(s0_data),
      .stall_count(s0_stall),
      .overflow(s0_ovf)
   );

   // Read mux
   always_comb begin
      if (paddr == DSM_OFS_IRQ_STATUS) begin
         rd_word = irq_status_word;
      end else if (paddr == DSM_OFS_EV_STATUS) begin
         rd_word = {28'h0, s_q.ev_stat};
      end else if (paddr == DSM_OFS_EV_MASK) begin
         rd_word = {28'h0, s_q.ev_mask};
      end else if (paddr == DSM_OFS_MON_CTRL) begin
         rd_word = s_q.mon_ctrl; // RQ7
      end else if (paddr == DSM_OFS_S0_DATA) begin
         rd_word = 32'(s0_data); // RQ11
      end else if (paddr == DSM_OFS_S0_STALL) begin
         rd_word = 32'(s0_stall); // RQ12
      end else begin
         rd_word = 32'h00000000;
      end
   end

   always_comb begin
      s_d = s_q;
      // One wait state: pready rises one edge into the access phase
      s_d.pready = acc_setup;
      s_d.pslverr = acc_setup && !dsm_mapped(paddr);
      s_d.prdata = (acc_setup && !pwrite) ? rd_word : 32'h00000000;

      // Register writes
      if (wr_done) begin
         if (paddr == DSM_OFS_MON_CTRL) begin
            s_d.mon_ctrl = pwdata & DSM_MON_CTRL_WMASK; // RQ4 RQ10 RQ7
         end else if (paddr == DSM_OFS_EV_MASK) begin
            s_d.ev_mask = pwdata[3:0];
         end
      end

      // Error flag: a new error wins over a clear in the same cycle
      s_d.err_flag = (s_q.err_flag && !error_clear_cmd) || xfer_err_in; // RQ1 RQ13

      // Transfer counter and reload
      if (chan_load.cnt_load) begin
         s_d.xfer_counter = chan_load.cnt_val;
      end else if (s_q.xfer_counter == 16'h0000 &&
                   s_q.reload_value != 16'h0000) begin
         s_d.xfer_counter = s_q.reload_value; // RQ14
      end else if (xfer_beat && s_q.chan_run) begin
         s_d.xfer_counter = s_q.xfer_counter - 16'h0001;
      end
      if (chan_load.rld_load) begin
         s_d.reload_value = chan_load.rld_val;
      end else if (s_q.xfer_counter == 16'h0000 &&
                   s_q.reload_value != 16'h0000) begin
         s_d.reload_value = DSM_RST_COUNT; // RQ14
      end
      // Channel may move data only with a count and no pending error
      s_d.chan_run = !s_d.err_flag &&
                     s_d.xfer_counter != 16'h0000; // RQ13 RQ14

      // Sticky events, set wins over write-one-to-clear
      s_d.cmpl_prev = cmpl_now;
      s_d.rz_prev = rz_now;
      if (wr_done && paddr == DSM_OFS_EV_STATUS) begin
         s_d.ev_stat = s_q.ev_stat & ~pwdata[3:0];
      end
      if (rz_now && !s_q.rz_prev) begin
         s_d.ev_stat[DSM_EV_RZ] = 1'b1;
      end
      if (cmpl_now && !s_q.cmpl_prev) begin
         s_d.ev_stat[DSM_EV_CMPL] = 1'b1;
      end
      if (xfer_err_in) begin
         s_d.ev_stat[DSM_EV_ERR] = 1'b1;
      end
      if (s0_ovf) begin
         s_d.ev_stat[DSM_EV_OVF] = 1'b1;
      end
      s_d.irq = |(s_d.ev_stat & s_d.ev_mask);
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.mon_ctrl <= DSM_RST_MON_CTRL;
         s_q.ev_mask <= DSM_RST_EV_MASK;
         s_q.cmpl_prev <= 1'b1;
         s_q.rz_prev <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign irq = s_q.irq;
   assign chan_run = s_q.chan_run;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_err_sets: assert property ( // RQ1
      xfer_err_in |=> s_q.err_flag && !chan_run)
      else $error("transfer error did not set the flag");
   chk_err_holds: assert property ( // RQ1
      (s_q.err_flag && !error_clear_cmd) |=> s_q.err_flag)
      else $error("error flag dropped without a clear");
   chk_err_clears: assert property ( // RQ13
      (error_clear_cmd && !xfer_err_in) |=> !s_q.err_flag)
      else $error("error clear command had no effect");
   chk_cmpl_read: assert property ( // RQ2
      (acc_setup && !pwrite && paddr == DSM_OFS_IRQ_STATUS) |=>
      prdata[DSM_BIT_CMPL] == ($past(s_q.xfer_counter) == 0 &&
                               $past(s_q.reload_value) == 0))
      else $error("complete flag read back wrong");
   chk_rz_read: assert property ( // RQ3
      (acc_setup && !pwrite && paddr == DSM_OFS_IRQ_STATUS) |=>
      prdata[DSM_BIT_RZ] == ($past(s_q.reload_value) == 0))
      else $error("reload zero flag read back wrong");
   chk_clr_bits_zero: assert property ( // RQ7
      (acc_setup && !pwrite && paddr == DSM_OFS_MON_CTRL) |=>
      prdata[DSM_BIT_S1_CLR:DSM_BIT_S0_CLR] == 2'b00)
      else $error("slot clear bits read as one");
   chk_slot_clear: assert property ( // RQ6
      s0_clear |=> s0_data == 0 && s0_stall == 0)
      else $error("slot clear did not zero counters");
   chk_reload_load: assert property ( // RQ14
      (s_q.xfer_counter == 0 && s_q.reload_value != 0 &&
       !chan_load.cnt_load && !chan_load.rld_load) |=>
      s_q.xfer_counter == $past(s_q.reload_value) &&
      s_q.reload_value == 0)
      else $error("counter not reloaded");
   chk_stop_at_zero: assert property ( // RQ14
      (s_q.xfer_counter == 0 && s_q.reload_value == 0 &&
       !chan_load.cnt_load) |=> !chan_run)
      else $error("channel kept running with no count");
   chk_apb_answer: assert property (
      acc_setup |=> pready ##1 !pready)
      else $error("pready not a single cycle one edge later");
   chk_irq_level: assert property (
      |(s_q.ev_stat & s_q.ev_mask) |-> irq)
      else $error("irq low with an unmasked event");

   // Bus answer shape and error response
   chk_apb_error: assert property (
      (acc_setup && !dsm_mapped(paddr)) |=> pready && pslverr &&
      prdata == 32'h00000000)
      else $error("unmapped access not answered with an error");
   chk_apb_quiet: assert property (
      !pready |-> prdata == 32'h00000000 && !pslverr)
      else $error("read data or error outside the answer cycle");

   // Channel select feeds slot 0 from the right strobe
   chk_sel_data: assert property ( // RQ4
      (32'(s0_sel) < NUM_CH) |-> s0_ev.rd_data == rd_data_ev[s0_sel])
      else $error("slot 0 watched the wrong data strobe");
   chk_sel_stall: assert property ( // RQ4
      (32'(s0_sel) < NUM_CH) |-> s0_ev.rd_stall == rd_stall_ev[s0_sel])
      else $error("slot 0 watched the wrong stall strobe");
   chk_ctrl_write: assert property ( // RQ4 RQ10
      (wr_done && paddr == DSM_OFS_MON_CTRL) |=>
      s0_sel == $past(pwdata[DSM_POS_S0_SEL +: DSM_SEL_W]) &&
      s_q.mon_ctrl[DSM_BIT_S0_EN] == $past(pwdata[DSM_BIT_S0_EN]))
      else $error("monitor control write not taken");
   chk_slot1_clear: assert property ( // RQ6
      (s1_clear && !s0_clear && !s_q.mon_ctrl[DSM_BIT_S0_EN]) |=>
      $stable(s0_data) && $stable(s0_stall))
      else $error("slot 1 clear disturbed slot 0");

   // Event status and channel counter bookkeeping
   chk_err_event: assert property ( // RQ1
      xfer_err_in |=> s_q.ev_stat[DSM_EV_ERR])
      else $error("transfer error did not set its event");
   chk_cmpl_event: assert property ( // RQ2
      (cmpl_now && !s_q.cmpl_prev) |=> s_q.ev_stat[DSM_EV_CMPL])
      else $error("complete flag rise did not set its event");
   chk_ovf_event: assert property (
      s0_ovf |=> s_q.ev_stat[DSM_EV_OVF])
      else $error("slot overflow did not set its event");
   chk_ev_clear: assert property (
      (wr_done && paddr == DSM_OFS_EV_STATUS && pwdata[DSM_EV_OVF] &&
       !s0_ovf) |=> !s_q.ev_stat[DSM_EV_OVF])
      else $error("write one did not clear the overflow event");
   chk_irq_quiet: assert property (
      !(|(s_q.ev_stat & s_q.ev_mask)) |-> !irq)
      else $error("irq high with no unmasked event");
   chk_mask_write: assert property (
      (wr_done && paddr == DSM_OFS_EV_MASK) |=>
      s_q.ev_mask == $past(pwdata[3:0]))
      else $error("event mask write not taken");
   chk_cnt_load: assert property (
      chan_load.cnt_load |=> s_q.xfer_counter == $past(chan_load.cnt_val))
      else $error("counter load not taken");
   chk_beat_step: assert property ( // RQ14
      (xfer_beat && chan_run && !chan_load.cnt_load) |=>
      s_q.xfer_counter == $past(s_q.xfer_counter) - 16'h0001)
      else $error("transfer beat did not step the counter");
   chk_run_resume: assert property ( // RQ13
      (error_clear_cmd && !xfer_err_in && !xfer_beat && !chan_load.cnt_load &&
       s_q.xfer_counter != 16'h0000) |=> chan_run)
      else $error("channel did not resume after error clear");

   cov_reload: cover property (
      s_q.xfer_counter == 0 && s_q.reload_value != 0);
   cov_err_clear: cover property (s_q.err_flag ##[1:20] error_clear_cmd);
   cov_irq: cover property ($rose(irq));
   cov_ovf: cover property (s0_ovf);
endmodule // dsm_top

// ---- sim/dsm_far_side.sv ----
// Model of the channel transfer logic and monitor strobe sources
`timescale 1ns/1ns
module dsm_far_side
   import dsm_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Channel side
   output dsm_chan_load_s chan_load,
   output logic xfer_beat,
   output logic xfer_err_in,
   // Monitor strobes
   output logic [63:0] rd_data_ev,
   output logic [63:0] rd_stall_ev
);
   initial begin
      chan_load = '0;
      xfer_beat = 1'b0;
      xfer_err_in = 1'b0;
      rd_data_ev = '0;
      rd_stall_ev = '0;
   end

   // Data cycles then stall cycles on ch; ch+1 is always busy as noise
   task automatic strobe(input int ch, input int nd, input int ns);
      logic [63:0] dv;
      logic [63:0] sv;
      for (int i = 0; i < nd + ns; i++) begin
         @(posedge core_clk);
         dv = '0;
         sv = '0;
         dv[ch + 1] = 1'b1;
         sv[ch + 1] = 1'b1;
         dv[ch] = (i < nd);
         sv[ch] = (i >= nd);
         rd_data_ev <= dv;
         rd_stall_ev <= sv;
      end
      @(posedge core_clk);
      rd_data_ev <= '0;
      rd_stall_ev <= '0;
   endtask

   task automatic load(input logic [15:0] c, input logic [15:0] r);
      @(posedge core_clk);
      chan_load <= '{1'b1, c, 1'b1, r};
      @(posedge core_clk);
      chan_load <= '0;
   endtask

   task automatic pulse(input logic err);
      @(posedge core_clk);
      xfer_err_in <= err;
      xfer_beat <= ~err;
      @(posedge core_clk);
      xfer_err_in <= 1'b0;
      xfer_beat <= 1'b0;
   endtask
endmodule // dsm_far_side

// ---- sim/dsm_status_perf_monitor_bench.sv ----
// Self-checking bench of the DMA status and performance monitor block
`timescale 1ns/1ns
module dma_status_perf_monitor_bench
   import dsm_pkg::*;
;
   logic core_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic xfer_beat, xfer_err_in, chan_run;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [63:0] rd_data_ev, rd_stall_ev;
   dsm_chan_load_s chan_load;
   int n_fail = 0;
   int num_checks = 0;

   dsm_top #(.NUM_CH(64), .CNT_W(4)) dut (.core_clk(core_clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chan_load(chan_load), .xfer_beat(xfer_beat),
      .xfer_err_in(xfer_err_in), .chan_run(chan_run),
      .rd_data_ev(rd_data_ev), .rd_stall_ev(rd_stall_ev), .irq(irq));
   dsm_far_side far (.core_clk(core_clk), .chan_load(chan_load),
      .xfer_beat(xfer_beat), .xfer_err_in(xfer_err_in),
      .rd_data_ev(rd_data_ev), .rd_stall_ev(rd_stall_ev));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
         if (n > 20) begin
            n_fail++;
            $display("MISMATCH pready expected 1 seen 0");
            print_verdict();
         end
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk($sformatf("read %h", a), exp, r);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic t_reset();
      rd(DSM_OFS_IRQ_STATUS, 32'h00000003);
      rd(DSM_OFS_MON_CTRL, DSM_RST_MON_CTRL);
      rd(DSM_OFS_S0_DATA, 32'h00000000);
      rd(DSM_OFS_S0_STALL, 32'h00000000);
   endtask

   task automatic t_chan();
      far.load(16'h0001, 16'h0001);
      rd(DSM_OFS_IRQ_STATUS, 32'h00000000);
      chk("chan_run", 32'h1, {31'h0, chan_run});
      far.pulse(1'b0);
      rd(DSM_OFS_IRQ_STATUS, 32'h00000001);
      far.pulse(1'b0);
      rd(DSM_OFS_IRQ_STATUS, 32'h00000003);
      far.pulse(1'b1);
      rd(DSM_OFS_IRQ_STATUS, 32'h00000007);
      wr(DSM_OFS_CHAN_CMD, 32'h00000000);
      rd(DSM_OFS_IRQ_STATUS, 32'h00000007);
      wr(DSM_OFS_CHAN_CMD, 32'h00000100);
      rd(DSM_OFS_IRQ_STATUS, 32'h00000003);
      far.load(16'h0002, 16'h0000);
      @(posedge core_clk);
      chk("chan_run", 32'h1, {31'h0, chan_run});
      far.pulse(1'b1);
      @(posedge core_clk);
      chk("chan_run", 32'h0, {31'h0, chan_run});
      wr(DSM_OFS_CHAN_CMD, 32'h00000100);
      @(posedge core_clk);
      chk("chan_run", 32'h1, {31'h0, chan_run});
   endtask

   task automatic t_count();
      // Slot 1 points elsewhere so the slots never share a channel
      wr(DSM_OFS_MON_CTRL, 32'h09050001);
      rd(DSM_OFS_MON_CTRL, 32'h09050001);
      far.strobe(5, 3, 2);
      rd(DSM_OFS_S0_DATA, 32'h00000003);
      rd(DSM_OFS_S0_STALL, 32'h00000002);
      wr(DSM_OFS_MON_CTRL, 32'h09050000);
      far.strobe(5, 2, 2);
      rd(DSM_OFS_S0_DATA, 32'h00000003);
      wr(DSM_OFS_MON_CTRL, 32'h09050000);
      rd(DSM_OFS_S0_STALL, 32'h00000002);
      wr(DSM_OFS_MON_CTRL, 32'h09050301);
      rd(DSM_OFS_MON_CTRL, 32'h09050001);
      rd(DSM_OFS_S0_DATA, 32'h00000000);
      rd(DSM_OFS_S0_STALL, 32'h00000000);
   endtask

   task automatic t_ovf();
      wr(DSM_OFS_EV_MASK, 32'h00000008);
      far.strobe(5, 0, 2);
      far.strobe(5, 16, 0);
      rd(DSM_OFS_S0_DATA, 32'h00000000);
      rd(DSM_OFS_S0_STALL, 32'h00000000);
      chk("irq", 32'h1, {31'h0, irq});
      rd(DSM_OFS_EV_STATUS, 32'h0000000F);
      wr(DSM_OFS_EV_STATUS, 32'h00000008);
      @(posedge core_clk);
      chk("irq", 32'h0, {31'h0, irq});
      rd(DSM_OFS_EV_STATUS, 32'h00000007);
   endtask

   task automatic t_freeze();
      wr(DSM_OFS_MON_CTRL, 32'h09050111);
      far.strobe(5, 0, 3);
      far.strobe(5, 20, 0);
      rd(DSM_OFS_S0_DATA, 32'h0000000F);
      rd(DSM_OFS_S0_STALL, 32'h00000003);
   endtask

   task automatic t_unmapped();
      logic [31:0] r;
      logic e;
      apb(1'b0, 12'h100, 32'h0, r, e);
      chk("unmapped error", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, r);
   endtask

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_chan();
      t_count();
      t_ovf();
      t_freeze();
      t_unmapped();
      print_verdict();
   end
endmodule // dma_status_perf_monitor_bench
